/* File: src/cct_top.sv */
// pair of cascadable 16-bit countdown timers with register port and irq
//
// Contract
// - timer b auto-reload restarts, else stops at zero
// - timer b underflow sets its irq flag
// - timer b tick select: fast, slow, a, c
// - start event loads timer b reload bytes
// - reload writes act only at next start or auto-reload
// - timer b count readable as two bytes
// - timer c stop-on-receive after four bits
// - stop-on-receive ignored in trimming modes
// - start mode 00 manual, 01 at tx end
// - modes 10/11 trim on rising oscillator edges
// - timer c auto-reload restarts, else stops
// - timer c underflow sets its irq flag
// - timer c tick select: fast, slow, a, b
// - timer b has stop-on-receive and start mode
`timescale 1ns/10ps
`include "cct_consts.svh"
module cct_top (
  input  wire logic       SYS_CLK,
  input  wire logic       SRST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       TICK_FAST,
  input  wire logic       TICK_SLOW,
  input  wire logic       TIMER_A_UNDERFLOW,
  input  wire logic       TX_END,
  input  wire logic       RX_FIRST_BITS,
  input  wire logic       SLOW_OSC,
  output logic            TIMER_B_UNDERFLOW,
  output logic            TIMER_C_UNDERFLOW,
  output logic            IRQ
);

  cct_pkg::cct_top_t cur_ff;
  cct_pkg::cct_top_t nxt_st;
  cct_if             osc_if ();

  logic [1:0]        cmd_start;
  logic [1:0]        cmd_stop;
  logic [1:0]        tick;
  logic [1:0]        start_ev;
  logic [1:0]        stop_ev;
  logic [1:0]        is_trim;
  logic [1:0]        uf_set;

  // the oscillator pin is asynchronous, so it passes the synchroniser
  assign osc_if.raw = SLOW_OSC;

  cct_sync u_sync (
    .clk  (SYS_CLK),
    .srst (SRST),
    .lnk  (osc_if)
  );

  // select one tick source; x is the other timer of the pair
  function automatic logic tick_of(
    input logic [1:0] sel,
    input logic       fast,
    input logic       slow,
    input logic       casc_a,
    input logic       casc_x
  );
    logic t;
    t = 1'b0;
    case (sel)
      `CCT_TICK_FAST:   t = fast;
      `CCT_TICK_SLOW:   t = slow;
      `CCT_TICK_CASC_A: t = casc_a;
      `CCT_TICK_CASC_X: t = casc_x;
      default:          t = 1'b0;
    endcase
    return t;
  endfunction

  // control register offset of timer i
  function automatic logic [7:0] ctrl_addr(input int unsigned i);
    return (i == 0) ? `CCT_ADDR_B_CTRL : `CCT_ADDR_C_CTRL;
  endfunction

  // reload high byte offset of timer i
  function automatic logic [7:0] rld_hi_addr(input int unsigned i);
    return (i == 0) ? `CCT_ADDR_B_RLD_HI : `CCT_ADDR_C_RLD_HI;
  endfunction

  // reload low byte offset of timer i
  function automatic logic [7:0] rld_lo_addr(input int unsigned i);
    return (i == 0) ? `CCT_ADDR_B_RLD_LO : `CCT_ADDR_C_RLD_LO;
  endfunction

  // command register: bit 2i starts timer i, bit 2i+1 stops it
  assign cmd_start[0] = REG_WR & (REG_ADDR == `CCT_ADDR_CMD) & REG_WDATA[0];
  assign cmd_stop[0]  = REG_WR & (REG_ADDR == `CCT_ADDR_CMD) & REG_WDATA[1];
  assign cmd_start[1] = REG_WR & (REG_ADDR == `CCT_ADDR_CMD) & REG_WDATA[2];
  assign cmd_stop[1]  = REG_WR & (REG_ADDR == `CCT_ADDR_CMD) & REG_WDATA[3];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_evt
      logic [1:0] mode;
      logic       stop_rx;
      logic       running;

      assign mode    = cur_ff.tmr[gi].ctrl_ff[`CCT_CTRL_MODE_HI:
                                              `CCT_CTRL_MODE_LO];
      assign stop_rx = cur_ff.tmr[gi].ctrl_ff[`CCT_CTRL_STOP_RX];
      assign running = cur_ff.tmr[gi].state_ff == cct_pkg::CCT_RUN;
      assign is_trim[gi] = mode[1];

      // registered underflow of the partner keeps the cascade loop-free
      assign tick[gi] = tick_of(
        cur_ff.tmr[gi].ctrl_ff[`CCT_CTRL_TICK_HI:`CCT_CTRL_TICK_LO],
        TICK_FAST,
        TICK_SLOW,
        TIMER_A_UNDERFLOW,
        cur_ff.tmr[1 - gi].uf_ff);

      // manual start only by command; tx end in mode 01
      assign start_ev[gi] = cmd_start[gi]
        | ((mode == `CCT_MODE_TX_END) & TX_END)
        | (mode[1] & osc_if.rise & ~running);

      // stop-on-receive is ignored while trimming
      assign stop_ev[gi] = cmd_stop[gi]
        | (stop_rx & ~mode[1] & RX_FIRST_BITS)
        | (mode[1] & osc_if.rise & running);
    end
  endgenerate

  always_comb begin
    nxt_st          = cur_ff;
    uf_set          = 2'h0;
    nxt_st.rdata_ff = 8'h00;

    for (int i = 0; i < 2; i++) begin
      nxt_st.tmr[i].uf_ff = 1'b0;

      // register writes; the counter itself is never touched here
      if (REG_WR && REG_ADDR == ctrl_addr(i)) begin
        nxt_st.tmr[i].ctrl_ff = REG_WDATA & `CCT_CTRL_WMASK;
      end
      if (REG_WR && REG_ADDR == rld_hi_addr(i)) begin
        nxt_st.tmr[i].rld_hi_ff = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == rld_lo_addr(i)) begin
        nxt_st.tmr[i].rld_lo_ff = REG_WDATA;
      end

      // stop wins when a start and a stop meet in one cycle
      if (stop_ev[i]) begin
        nxt_st.tmr[i].state_ff = cct_pkg::CCT_IDLE;
      end else if (start_ev[i]) begin
        nxt_st.tmr[i].state_ff = cct_pkg::CCT_RUN;
        nxt_st.tmr[i].count_ff = {cur_ff.tmr[i].rld_hi_ff,
                                  cur_ff.tmr[i].rld_lo_ff};
      end else if (cur_ff.tmr[i].state_ff == cct_pkg::CCT_RUN
                   && tick[i]) begin
        if (cur_ff.tmr[i].count_ff == `CCT_COUNT_RESET) begin
          if (cur_ff.tmr[i].ctrl_ff[`CCT_CTRL_MODE_HI:`CCT_CTRL_MODE_LO]
              == `CCT_MODE_TRIM) begin
            // trimming without underflow parks at zero until the edge
            nxt_st.tmr[i].count_ff = `CCT_COUNT_RESET;
          end else begin
            nxt_st.tmr[i].uf_ff = 1'b1;
            uf_set[i]           = 1'b1;
            if (cur_ff.tmr[i].ctrl_ff[`CCT_CTRL_AUTO]) begin
              nxt_st.tmr[i].count_ff = {cur_ff.tmr[i].rld_hi_ff,
                                        cur_ff.tmr[i].rld_lo_ff};
            end else begin
              nxt_st.tmr[i].state_ff = cct_pkg::CCT_IDLE;
            end
          end
        end else begin
          nxt_st.tmr[i].count_ff = cur_ff.tmr[i].count_ff - 16'h0001;
        end
      end
    end

    // sticky flags: write one clears, a new underflow wins over the clear
    if (REG_WR && REG_ADDR == `CCT_ADDR_IRQ_STAT) begin
      nxt_st.irq_stat_ff = cur_ff.irq_stat_ff & ~REG_WDATA;
    end
    nxt_st.irq_stat_ff = nxt_st.irq_stat_ff | {6'h00, uf_set};

    if (REG_WR && REG_ADDR == `CCT_ADDR_IRQ_MASK) begin
      nxt_st.irq_mask_ff = REG_WDATA & 8'h03;
    end

    // read data stand only in the cycle after the strobe
    if (REG_RD) begin
      case (REG_ADDR)
        `CCT_ADDR_B_CTRL: begin
          nxt_st.rdata_ff = cur_ff.tmr[0].ctrl_ff;
        end
        `CCT_ADDR_B_RLD_HI: begin
          nxt_st.rdata_ff = cur_ff.tmr[0].rld_hi_ff;
        end
        `CCT_ADDR_B_RLD_LO: begin
          nxt_st.rdata_ff = cur_ff.tmr[0].rld_lo_ff;
        end
        // live value; a read mid-count may tear between the two bytes
        `CCT_ADDR_B_CNT_HI: begin
          nxt_st.rdata_ff = cur_ff.tmr[0].count_ff[15:8];
        end
        `CCT_ADDR_B_CNT_LO: begin
          nxt_st.rdata_ff = cur_ff.tmr[0].count_ff[7:0];
        end
        `CCT_ADDR_C_CTRL: begin
          nxt_st.rdata_ff = cur_ff.tmr[1].ctrl_ff;
        end
        `CCT_ADDR_C_RLD_HI: begin
          nxt_st.rdata_ff = cur_ff.tmr[1].rld_hi_ff;
        end
        `CCT_ADDR_C_RLD_LO: begin
          nxt_st.rdata_ff = cur_ff.tmr[1].rld_lo_ff;
        end
        `CCT_ADDR_IRQ_STAT: begin
          nxt_st.rdata_ff = cur_ff.irq_stat_ff;
        end
        `CCT_ADDR_IRQ_MASK: begin
          nxt_st.rdata_ff = cur_ff.irq_mask_ff;
        end
        `CCT_ADDR_CMD: begin
          nxt_st.rdata_ff = {4'h0, osc_if.level, is_trim[1],
            cur_ff.tmr[1].state_ff == cct_pkg::CCT_RUN,
            cur_ff.tmr[0].state_ff == cct_pkg::CCT_RUN};
        end
        default: begin
          nxt_st.rdata_ff = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 2; i++) begin
        cur_ff.tmr[i].ctrl_ff   <= `CCT_CTRL_RESET;
        cur_ff.tmr[i].rld_hi_ff <= `CCT_RELOAD_RESET;
        cur_ff.tmr[i].rld_lo_ff <= `CCT_RELOAD_RESET;
        cur_ff.tmr[i].count_ff  <= `CCT_COUNT_RESET;
        cur_ff.tmr[i].state_ff  <= cct_pkg::CCT_IDLE;
        cur_ff.tmr[i].uf_ff     <= 1'b0;
      end
      cur_ff.irq_stat_ff <= `CCT_IRQ_RESET;
      cur_ff.irq_mask_ff <= `CCT_IRQ_RESET;
      cur_ff.rdata_ff    <= 8'h00;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign REG_RDATA         = cur_ff.rdata_ff;
  assign TIMER_B_UNDERFLOW = cur_ff.tmr[0].uf_ff;
  assign TIMER_C_UNDERFLOW = cur_ff.tmr[1].uf_ff;
  assign IRQ = |(cur_ff.irq_stat_ff & cur_ff.irq_mask_ff);
endmodule // cct_top

/* File: src/cct_consts.svh */
// register offsets, control fields, reset values and codes of the timer pair
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH
`define CCT_ADDR_B_CTRL    8'h14
`define CCT_ADDR_B_RLD_HI  8'h15
`define CCT_ADDR_B_RLD_LO  8'h16
`define CCT_ADDR_B_CNT_HI  8'h17
`define CCT_ADDR_B_CNT_LO  8'h18
`define CCT_ADDR_C_CTRL    8'h19
`define CCT_ADDR_C_RLD_HI  8'h1A
`define CCT_ADDR_C_RLD_LO  8'h1B
`define CCT_ADDR_IRQ_STAT  8'h30
`define CCT_ADDR_IRQ_MASK  8'h31
`define CCT_ADDR_CMD       8'h32
`define CCT_CTRL_STOP_RX   7
`define CCT_CTRL_MODE_HI   5
`define CCT_CTRL_MODE_LO   4
`define CCT_CTRL_AUTO      3
`define CCT_CTRL_TICK_HI   1
`define CCT_CTRL_TICK_LO   0
`define CCT_CTRL_WMASK     8'hBB
`define CCT_CTRL_RESET     8'h00
`define CCT_RELOAD_RESET   8'h00
`define CCT_COUNT_RESET    16'h0000
`define CCT_IRQ_RESET      8'h00
`define CCT_MODE_MANUAL    2'h0
`define CCT_MODE_TX_END    2'h1
`define CCT_MODE_TRIM      2'h2
`define CCT_MODE_TRIM_UF   2'h3
`define CCT_TICK_FAST      2'h0
`define CCT_TICK_SLOW      2'h1
`define CCT_TICK_CASC_A    2'h2
`define CCT_TICK_CASC_X    2'h3
`endif

/* File: src/cct_pkg.sv */
// types shared by the timer pair
package cct_pkg;
  typedef enum logic {
    CCT_IDLE,
    CCT_RUN
  } cct_run_t;
  typedef struct packed {
    logic [7:0]  ctrl_ff;
    logic [7:0]  rld_hi_ff;
    logic [7:0]  rld_lo_ff;
    logic [15:0] count_ff;
    cct_run_t    state_ff;
    logic        uf_ff;
  } cct_timer_t;
  typedef struct packed {
    cct_timer_t [1:0] tmr;
    logic [7:0]       irq_stat_ff;
    logic [7:0]       irq_mask_ff;
    logic [7:0]       rdata_ff;
  } cct_top_t;
  typedef struct packed {
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
  } cct_sync_t;
endpackage

/* File: src/cct_if.sv */
// slow oscillator pin and its synchronised level and rising-edge pulse
`timescale 1ns/10ps
interface cct_if;
  logic raw;
  logic level;
  logic rise;
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

/* File: src/cct_sync.sv */
// two-flop synchroniser with rising-edge detect for the slow oscillator
`timescale 1ns/10ps
module cct_sync (
  input  wire logic clk,
  input  wire logic srst,
  cct_if.sync       lnk
);
  cct_pkg::cct_sync_t cur_ff;
  cct_pkg::cct_sync_t nxt_st;

  // edge is taken between the second and third flop, never the first
  always_comb begin
    nxt_st       = cur_ff;
    nxt_st.s1_ff = lnk.raw;
    nxt_st.s2_ff = cur_ff.s1_ff;
    nxt_st.s3_ff = cur_ff.s2_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign lnk.level = cur_ff.s2_ff;
  assign lnk.rise  = cur_ff.s2_ff & ~cur_ff.s3_ff;
endmodule // cct_sync

/* File: verif/cct_top_chk.sv */
// concurrent checks on the ports of the timer pair
`timescale 1ns/10ps
`include "cct_consts.svh"
module cct_top_chk (
  input wire logic       SYS_CLK,
  input wire logic       SRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       TICK_FAST,
  input wire logic       TICK_SLOW,
  input wire logic       TIMER_A_UNDERFLOW,
  input wire logic       TX_END,
  input wire logic       RX_FIRST_BITS,
  input wire logic       SLOW_OSC,
  input wire logic       TIMER_B_UNDERFLOW,
  input wire logic       TIMER_C_UNDERFLOW,
  input wire logic       IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  a_rdata_idle_zero: assert property (
    !$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("read data off idle");
  a_b_ctrl_rsvd: assert property (
    REG_RD && REG_ADDR == `CCT_ADDR_B_CTRL |=> (REG_RDATA & 8'h44) == 8'h00)
    else $error("timer b control reserved bit set");
  a_c_ctrl_rsvd: assert property (
    REG_RD && REG_ADDR == `CCT_ADDR_C_CTRL |=> (REG_RDATA & 8'h44) == 8'h00)
    else $error("timer c control reserved bit set");
  a_mask_two_bits: assert property (
    REG_RD && REG_ADDR == `CCT_ADDR_IRQ_MASK |=> REG_RDATA[7:2] == 6'h00)
    else $error("mask wider than two bits");
  a_stat_two_bits: assert property (
    REG_RD && REG_ADDR == `CCT_ADDR_IRQ_STAT |=> REG_RDATA[7:2] == 6'h00)
    else $error("status wider than two bits");
  a_b_uf_cause: assert property (TIMER_B_UNDERFLOW |->
    $past(TICK_FAST || TICK_SLOW || TIMER_A_UNDERFLOW || TIMER_C_UNDERFLOW))
    else $error("timer b underflow without tick");
  a_c_uf_cause: assert property (TIMER_C_UNDERFLOW |->
    $past(TICK_FAST || TICK_SLOW || TIMER_A_UNDERFLOW || TIMER_B_UNDERFLOW))
    else $error("timer c underflow without tick");
  // only a register write can drop a sticky interrupt
  a_irq_sticky: assert property (IRQ && !REG_WR |=> IRQ)
    else $error("interrupt dropped without write");
  a_irq_rise_cause: assert property ($rose(IRQ) |->
    TIMER_B_UNDERFLOW || TIMER_C_UNDERFLOW || $past(REG_WR))
    else $error("interrupt rose without cause");
  c_b_uf: cover property (TIMER_B_UNDERFLOW);
  c_c_uf: cover property (TIMER_C_UNDERFLOW);
  c_irq: cover property ($rose(IRQ));
endmodule // cct_top_chk
bind cct_top cct_top_chk u_chk (.SYS_CLK, .SRST, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA, .TICK_FAST, .TICK_SLOW, .TIMER_A_UNDERFLOW,
  .TX_END, .RX_FIRST_BITS, .SLOW_OSC, .TIMER_B_UNDERFLOW, .TIMER_C_UNDERFLOW,
  .IRQ);

/* File: verif/cct_top_tb.sv */
// self-checking bench for the timer pair
`timescale 1ns/10ps
module cct_top_tb;
  logic       SYS_CLK, SRST, REG_WR, REG_RD, TICK_FAST, TICK_SLOW;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
  logic       TX_END, RX_FIRST_BITS, SLOW_OSC, IRQ, TIMER_A_UNDERFLOW;
  logic       TIMER_B_UNDERFLOW, TIMER_C_UNDERFLOW;
  int         bad_count, check_count;
  // first timer is outside this block, so the bench pulses its underflow
  cct_top DUT (.SYS_CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .TICK_FAST, .TICK_SLOW, .TIMER_A_UNDERFLOW, .TX_END,
    .RX_FIRST_BITS, .SLOW_OSC, .TIMER_B_UNDERFLOW, .TIMER_C_UNDERFLOW, .IRQ);
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task pls(input logic [2:0] v);
    @(posedge SYS_CLK);
    {TICK_FAST, TX_END, RX_FIRST_BITS} <= v;
    @(posedge SYS_CLK);
    {TICK_FAST, TX_END, RX_FIRST_BITS} <= 3'b000;
  endtask
  // pin passes two sync flops and an edge stage before it counts
  task osc(input logic v);
    @(posedge SYS_CLK);
    SLOW_OSC <= v;
    repeat (4) @(posedge SYS_CLK);
  endtask
  task wuf(input bit c);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge SYS_CLK);
      #1;
      if ((c ? TIMER_C_UNDERFLOW : TIMER_B_UNDERFLOW) === 1'b1) break;
    end
    if (i == 300) begin
      bad_count++;
      complete_run;
    end
  endtask
  task t_regs;
    rd(8'h15);
    chk(d, 8'h00);
    wr(8'h14, 8'hFF);
    rd(8'h14);
    chk(d, 8'hBB);
    wr(8'h19, 8'hFF);
    rd(8'h19);
    chk(d, 8'hBB);
    wr(8'h20, 8'h5A);
    rd(8'h20);
    chk(d, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h19, 8'h00);
    $display("registers test done");
  endtask
  task t_oneshot;
    wr(8'h16, 8'h03);
    wr(8'h30, 8'hFF);
    wr(8'h32, 8'h01);
    rd(8'h18);
    chk(d, 8'h03);
    wr(8'h16, 8'h09);
    rd(8'h18);
    chk(d, 8'h03);
    pls(3'b100);
    rd(8'h18);
    chk(d, 8'h02);
    @(posedge SYS_CLK);
    TICK_FAST <= 1'b1;
    wuf(1'b0);
    @(posedge SYS_CLK);
    TICK_FAST <= 1'b0;
    rd(8'h32);
    chk(d & 8'h01, 8'h00);
    rd(8'h17);
    chk(d, 8'h00);
    chk({7'h00, IRQ}, 8'h00);
    rd(8'h30);
    chk(d, 8'h01);
    wr(8'h31, 8'h01);
    #1 chk({7'h00, IRQ}, 8'h01);
    wr(8'h30, 8'h01);
    #1 chk({7'h00, IRQ}, 8'h00);
    wr(8'h32, 8'h01);
    rd(8'h18);
    chk(d, 8'h09);
    wr(8'h32, 8'h02);
    $display("one-shot test done");
  endtask
  task t_cascade;
    wr(8'h16, 8'h01);
    wr(8'h14, 8'h09);
    wr(8'h19, 8'h03);
    wr(8'h1B, 8'h01);
    wr(8'h32, 8'h05);
    @(posedge SYS_CLK);
    TICK_SLOW <= 1'b1;
    wuf(1'b1);
    @(posedge SYS_CLK);
    TICK_SLOW <= 1'b0;
    rd(8'h32);
    chk(d & 8'h03, 8'h01);
    rd(8'h30);
    chk(d, 8'h03);
    wr(8'h32, 8'h02);
    wr(8'h30, 8'h03);
    wr(8'h14, 8'h02);
    wr(8'h32, 8'h01);
    @(posedge SYS_CLK);
    TIMER_A_UNDERFLOW <= 1'b1;
    @(posedge SYS_CLK);
    TIMER_A_UNDERFLOW <= 1'b0;
    rd(8'h18);
    chk(d, 8'h00);
    wr(8'h32, 8'h02);
    $display("cascade test done");
  endtask
  task t_events;
    wr(8'h14, 8'h10);
    pls(3'b010);
    rd(8'h32);
    chk(d & 8'h01, 8'h01);
    wr(8'h32, 8'h02);
    wr(8'h14, 8'h00);
    pls(3'b010);
    rd(8'h32);
    chk(d & 8'h01, 8'h00);
    wr(8'h19, 8'h90);
    pls(3'b010);
    pls(3'b001);
    rd(8'h32);
    chk(d & 8'h02, 8'h00);
    wr(8'h19, 8'h10);
    pls(3'b010);
    pls(3'b001);
    rd(8'h32);
    chk(d & 8'h02, 8'h02);
    wr(8'h32, 8'h08);
    wr(8'h19, 8'hA0);
    osc(1'b1);
    pls(3'b001);
    rd(8'h32);
    chk(d & 8'h02, 8'h02);
    osc(1'b0);
    osc(1'b1);
    rd(8'h32);
    chk(d & 8'h02, 8'h00);
    chk(d & 8'h0C, 8'h0C);
    $display("event test done");
  endtask
  initial begin
    {SRST, REG_WR, REG_RD, TICK_FAST, TICK_SLOW} = 5'h10;
    {TX_END, RX_FIRST_BITS, SLOW_OSC, TIMER_A_UNDERFLOW} = 4'h0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge SYS_CLK);
    SRST <= 1'b0;
    t_regs;
    t_oneshot;
    t_cascade;
    t_events;
    complete_run;
  end
endmodule // cct_top_tb
